// ---- its_consts.svh ----
// Constants for the interrupt table I/O sequencer.
// Assumes inclusion by bare name from design files.
`ifndef ITS_CONSTS_SVH
`define ITS_CONSTS_SVH
`define ITS_NUM_LINES 24
`define ITS_WORD_W 24
`define ITS_ADDR_W 14
`define ITS_N_HI 23
`define ITS_N_LO 18
`define ITS_C_HI 17
`define ITS_C_LO 16
`define ITS_P_HI 15
`define ITS_P_LO 14
`define ITS_Y_HI 13
`define ITS_N_FULL 6'h3f
`define ITS_INC_C_BIT 16
`define ITS_INC_Y_BIT 0
`define ITS_ROT_P00 5'h06
`define ITS_ROT_P01 5'h08
`define ITS_ROT_P10 5'h0c
`define ITS_OP_IN 3'h5
`define ITS_OP_OUT 3'h4
`define ITS_FIFO_DEPTH 16
`define ITS_CHAR_W 24
`endif

// ---- its_fifo.sv ----
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes single clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module its_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= ptr_inc(wr_reg);
      end
      if (pop)
      begin
        rd_reg <= ptr_inc(rd_reg);
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- its_mem_model.sv ----
// Core memory model on the sequencer's memory port.
// Assumes one requester; read latency is set through lat.
`timescale 1ns/1ps
`default_nettype none
`include "its_consts.svh"
module its_mem_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Memory port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [`ITS_ADDR_W-1:0] addr_i,
  input wire logic [`ITS_WORD_W-1:0] wdata_i,
  output logic rvalid_o,
  output logic [`ITS_WORD_W-1:0] rdata_o
);
  // --------------------------------
  // Storage and read timing
  // --------------------------------
  logic [`ITS_WORD_W-1:0] mem [16384];
  int lat = 1;
  int cnt;
  logic done;
  // Data toggles outside valid so a stale word never looks good
  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      cnt <= 0;
      done <= 1'b0;
    end
    else
    begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!req_i || we_i)
      begin
        cnt <= 0;
        done <= 1'b0;
      end
      else if (!done && cnt + 1 >= lat)
      begin
        rvalid_o <= 1'b1;
        rdata_o <= mem[addr_i];
        done <= 1'b1;
      end
      else if (!done)
        cnt <= cnt + 1;
      if (req_i && we_i)
        mem[addr_i] = wdata_i;
    end
  end
endmodule
`default_nettype wire

// ---- its_pkg.sv ----
// Types for the interrupt table I/O sequencer.
// Assumes its_consts.svh is available.
`include "its_consts.svh"
package its_pkg;
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_S1,
    ST_S3,
    ST_S4_RD,
    ST_S4_OUT,
    ST_S5,
    ST_STOP
  } its_state_t;
  typedef struct packed {
    logic [3:0] dev_code;
    logic input_dir;
    logic [`ITS_ADDR_W-1:0] resp_addr;
  } its_map_t;
  typedef struct packed {
    logic [3:0] dev_code;
    logic [2:0] op_code;
    logic [`ITS_CHAR_W-1:0] data;
  } its_char_t;
endpackage

// ---- its_seq_props.sv ----
// Checker on the table I/O sequencer ports.
// Assumes a bind to its_sequencer from the testbench top.
`timescale 1ns/1ps
`default_nettype none
`include "its_consts.svh"
module its_seq_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic [`ITS_NUM_LINES-1:0] irq_i,
  input wire logic [`ITS_NUM_LINES-1:0] irq_ack_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic char_valid_o,
  input wire logic char_ready_i,
  input wire logic [2:0] char_op_o,
  input wire logic table_transfer_active_o,
  input wire logic end_of_table_echo_o,
  input wire logic transfer_stop_o,
  input wire logic busy_o
);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  ack_one_line_a: assert property ($onehot0(irq_ack_o))
    else $error("ack on two lines");
  idle_take_a: assert property (!busy_o && |irq_i |=> busy_o)
    else $error("request not taken");
  active_flag_a: assert property (busy_o || |irq_i |-> table_transfer_active_o)
    else $error("active flag low");
  idle_quiet_a: assert property (!busy_o |-> !mem_req_o)
    else $error("memory used while idle");
  write_once_a: assert property (mem_we_o |=> !mem_we_o)
    else $error("write held two cycles");
  stop_nowrite_a: assert property (transfer_stop_o |-> !mem_we_o [*3])
    else $error("write after stop");
  echo_pulse_a: assert property (end_of_table_echo_o |-> !transfer_stop_o ##1 !end_of_table_echo_o)
    else $error("echo wrong");
  op_code_a: assert property (char_valid_o |-> char_op_o inside {3'h4, 3'h5})
    else $error("bad op code");
  ack_idle_a: assert property (|irq_ack_o |=> !busy_o)
    else $error("busy after ack");
  cover property (end_of_table_echo_o);
  cover property (transfer_stop_o);
  cover property (char_valid_o && !char_ready_i);
endmodule
`default_nettype wire

// ---- its_sequencer.sv ----
// Interrupt-driven table output sequencer with memory port and char FIFO.
// Assumes an any-latency core memory port with read valid and peripheral interrupt levels.
// Function
// - Write updated control word back to response address
// - Read data word; rotate left 6, 8, 12 or 0 by packing field
// - Four chars per word: rotate left 6
// - Send low character to mapped device
// - Store rotated word back at table address
// - Repeat sequence on every channel interrupt
// - Exhausted control word ends without data
// - Fixed per-line map gives device code
// - Twenty-four interrupt lines, twenty-four reserved
// - Direction flag selects op 5, else 4
// - Table transfer active on any interrupt
// - Run states 1, 3, 4, 5; skip 2
// - State 1: fetch control word, clear increment
// - Increment bit 16 always; bit 0 if C==P
// - Sum increment and control word into both
// - Echo when C carry makes N full
// - Stop on bit-23 carry or full N
// - Termination goes to stop state; else go 3
// - Packing field two's-complement chars per word
// - State 3: C zero reloads from packing
`timescale 1ns/1ps
`default_nettype none
`include "its_consts.svh"
module its_sequencer #(
  parameter its_pkg::its_map_t LINE_MAP [`ITS_NUM_LINES] = '{default: '0}
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Interrupt lines
  input wire logic [`ITS_NUM_LINES-1:0] irq_i,
  output logic [`ITS_NUM_LINES-1:0] irq_ack_o,
  // Core memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [`ITS_ADDR_W-1:0] mem_addr_o,
  output logic [`ITS_WORD_W-1:0] mem_wdata_o,
  input wire logic mem_rvalid_i,
  input wire logic [`ITS_WORD_W-1:0] mem_rdata_i,
  // Character output stream
  output logic char_valid_o,
  input wire logic char_ready_i,
  output logic [3:0] char_dev_o,
  output logic [2:0] char_op_o,
  output logic [`ITS_CHAR_W-1:0] char_data_o,
  // Status
  output logic table_transfer_active_o,
  output logic end_of_table_echo_o,
  output logic transfer_stop_o,
  output logic input_direction_flag_o,
  output logic busy_o
);
  localparam int CW = 4 + 3 + `ITS_CHAR_W;
  its_pkg::its_state_t state_reg;
  logic [`ITS_WORD_W-1:0] stage_reg;
  logic [`ITS_WORD_W-1:0] incr_reg;
  logic [4:0] line_reg;
  logic [`ITS_NUM_LINES-1:0] ack_reg;
  logic echo_reg;
  logic stop_reg;
  logic rd_wait_reg;
  its_pkg::its_map_t map_cur;
  its_pkg::its_char_t char_in;
  logic [CW-1:0] char_out;
  logic fifo_ready;
  logic any_irq;
  logic [4:0] pick;
  logic [`ITS_WORD_W:0] sum;
  logic c_carry;
  logic [1:0] pack;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`ITS_WORD_W-1:0] rotl(input logic [`ITS_WORD_W-1:0] w,
                                                  input logic [1:0] p);
    logic [4:0] n;
    n = 5'h00;
    case (p)
      2'b00: n = `ITS_ROT_P00;
      2'b01: n = `ITS_ROT_P01;
      2'b10: n = `ITS_ROT_P10;
      default: n = 5'h00;
    endcase
    rotl = (w << n) | (w >> (5'd24 - n));
  endfunction

  // ----------------------------------------
  // Line selection and mapping
  // ----------------------------------------
  assign any_irq = |irq_i;
  always_comb
  begin
    pick = 5'h00;
    for (int i = `ITS_NUM_LINES - 1; i >= 0; i--)
    begin
      if (irq_i[i])
      begin
        pick = 5'(i);
      end
    end
  end
  assign map_cur = LINE_MAP[line_reg];
  assign pack = stage_reg[`ITS_P_HI:`ITS_P_LO];
  // Sum of control word and increment; carries decoded from it
  assign sum = {1'b0, stage_reg} + {1'b0, incr_reg};
  assign c_carry = sum[`ITS_N_LO] ^ stage_reg[`ITS_N_LO] ^ incr_reg[`ITS_N_LO];

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  // A stopped request returns straight to wait, so a line still high is served again.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= its_pkg::ST_WAIT;
      line_reg <= 5'h00;
      rd_wait_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        its_pkg::ST_WAIT:
        begin
          if (any_irq)
          begin
            line_reg <= pick;
            state_reg <= its_pkg::ST_S1;
            rd_wait_reg <= 1'b1;
          end
        end
        its_pkg::ST_S1:
        begin
          if (mem_rvalid_i)
          begin
            rd_wait_reg <= 1'b0;
          end
          else if (!rd_wait_reg)
          begin
            // Exhausted word goes to the stop state without data motion
            if (sum[`ITS_WORD_W] ||
                (stage_reg[`ITS_N_HI:`ITS_N_LO] == `ITS_N_FULL && !c_carry))
            begin
              state_reg <= its_pkg::ST_STOP;
            end
            else
            begin
              state_reg <= its_pkg::ST_S3;
            end
          end
        end
        its_pkg::ST_S3:
        begin
          state_reg <= its_pkg::ST_S4_RD;
          rd_wait_reg <= 1'b1;
        end
        its_pkg::ST_S4_RD:
        begin
          if (mem_rvalid_i)
          begin
            state_reg <= its_pkg::ST_S4_OUT;
            rd_wait_reg <= 1'b0;
          end
        end
        its_pkg::ST_S4_OUT:
        begin
          if (fifo_ready)
          begin
            state_reg <= its_pkg::ST_S5;
          end
        end
        its_pkg::ST_S5:
        begin
          state_reg <= its_pkg::ST_WAIT;
        end
        its_pkg::ST_STOP:
        begin
          state_reg <= its_pkg::ST_WAIT;
        end
        default:
        begin
          state_reg <= its_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Staging and increment registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage_reg <= '0;
      incr_reg <= '0;
    end
    else
    begin
      case (state_reg)
        its_pkg::ST_S1:
        begin
          if (mem_rvalid_i)
          begin
            stage_reg <= mem_rdata_i;
            incr_reg <= '0;
            incr_reg[`ITS_INC_C_BIT] <= 1'b1;
            incr_reg[`ITS_INC_Y_BIT] <=
              (mem_rdata_i[`ITS_C_HI:`ITS_C_LO] == mem_rdata_i[`ITS_P_HI:`ITS_P_LO]);
          end
          else if (!rd_wait_reg)
          begin
            stage_reg <= sum[`ITS_WORD_W-1:0];
            incr_reg <= sum[`ITS_WORD_W-1:0];
          end
        end
        its_pkg::ST_S3:
        begin
          if (stage_reg[`ITS_C_HI:`ITS_C_LO] == 2'b00)
          begin
            incr_reg[`ITS_C_HI:`ITS_C_LO] <= pack;
          end
        end
        its_pkg::ST_S4_RD:
        begin
          if (mem_rvalid_i)
          begin
            stage_reg <= rotl(mem_rdata_i, incr_reg[`ITS_P_HI:`ITS_P_LO]);
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Echo, stop and acknowledge
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      echo_reg <= 1'b0;
      stop_reg <= 1'b0;
      ack_reg <= '0;
    end
    else
    begin
      echo_reg <= 1'b0;
      stop_reg <= 1'b0;
      ack_reg <= '0;
      if (state_reg == its_pkg::ST_S1 && !mem_rvalid_i && !rd_wait_reg)
      begin
        echo_reg <= c_carry && !sum[`ITS_WORD_W] &&
                    (sum[`ITS_N_HI:`ITS_N_LO] == `ITS_N_FULL);
        stop_reg <= sum[`ITS_WORD_W] ||
                    (stage_reg[`ITS_N_HI:`ITS_N_LO] == `ITS_N_FULL && !c_carry);
      end
      if (state_reg == its_pkg::ST_S5 || state_reg == its_pkg::ST_STOP)
      begin
        ack_reg[line_reg] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  always_comb
  begin
    mem_req_o = 1'b0;
    mem_we_o = 1'b0;
    mem_addr_o = map_cur.resp_addr;
    mem_wdata_o = incr_reg;
    case (state_reg)
      its_pkg::ST_S1:
      begin
        mem_req_o = rd_wait_reg && !mem_rvalid_i;
      end
      its_pkg::ST_S3:
      begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        if (stage_reg[`ITS_C_HI:`ITS_C_LO] == 2'b00)
        begin
          mem_wdata_o = {incr_reg[`ITS_N_HI:`ITS_N_LO], pack,
                         incr_reg[`ITS_P_HI:0]};
        end
      end
      its_pkg::ST_S4_RD:
      begin
        mem_req_o = !mem_rvalid_i;
        mem_addr_o = incr_reg[`ITS_Y_HI:0];
      end
      its_pkg::ST_S5:
      begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        mem_addr_o = incr_reg[`ITS_Y_HI:0];
        mem_wdata_o = stage_reg;
      end
      default:
      begin
      end
    endcase
  end

  // ----------------------------------------
  // Character path
  // ----------------------------------------
  // Full word goes out; the device keeps only its character width.
  assign char_in.dev_code = map_cur.dev_code;
  assign char_in.op_code = map_cur.input_dir ? `ITS_OP_IN : `ITS_OP_OUT;
  assign char_in.data = stage_reg;

  its_fifo #(
    .WIDTH(CW),
    .DEPTH(`ITS_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(state_reg == its_pkg::ST_S4_OUT),
    .in_ready_o(fifo_ready),
    .in_data_i(char_in),
    .out_valid_o(char_valid_o),
    .out_ready_i(char_ready_i),
    .out_data_o(char_out)
  );
  assign char_dev_o = char_out[CW-1 -: 4];
  assign char_op_o = char_out[`ITS_CHAR_W +: 3];
  assign char_data_o = char_out[`ITS_CHAR_W-1:0];

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign table_transfer_active_o = any_irq || (state_reg != its_pkg::ST_WAIT);
  assign end_of_table_echo_o = echo_reg;
  assign transfer_stop_o = stop_reg;
  assign input_direction_flag_o = map_cur.input_dir;
  assign irq_ack_o = ack_reg;
  assign busy_o = (state_reg != its_pkg::ST_WAIT);
endmodule
`default_nettype wire

// ---- its_sequencer_tb.sv ----
// Self-checking bench for the table I/O sequencer.
// Assumes its_mem_model as core memory and the bench as sink.
`timescale 1ns/1ps
`default_nettype none
`include "its_consts.svh"
module its_sequencer_tb;
  // --------------------------------
  // Stimulus and bookkeeping
  // --------------------------------
  localparam its_pkg::its_map_t MAP [`ITS_NUM_LINES] = '{0: '{4'hc, 1'b0, 14'h0100},
    1: '{4'h3, 1'b1, 14'h0101}, 2: '{4'h5, 1'b0, 14'h0102},
    3: '{4'ha, 1'b1, 14'h0103}, default: '0};
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [`ITS_NUM_LINES-1:0] irq_i = '0;
  logic char_ready_i = 1'b1;
  logic [`ITS_NUM_LINES-1:0] irq_ack_o;
  logic mem_req_o, mem_we_o, mem_rvalid_i, char_valid_o, tta, echo, stop, busy_o, idf;
  logic [`ITS_ADDR_W-1:0] mem_addr_o;
  logic [`ITS_WORD_W-1:0] mem_wdata_o, mem_rdata_i, char_data_o;
  logic [3:0] char_dev_o;
  logic [2:0] char_op_o;
  its_pkg::its_char_t exp_q [$];
  int n_fail = 0;
  int total_checks = 0;
  int n_echo = 0;
  int n_stop = 0;
  always #12.5 mclk_i = ~mclk_i;
  its_sequencer #(.LINE_MAP(MAP)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .irq_i(irq_i),
    .irq_ack_o(irq_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .char_valid_o(char_valid_o), .char_ready_i(char_ready_i),
    .char_dev_o(char_dev_o), .char_op_o(char_op_o), .char_data_o(char_data_o),
    .table_transfer_active_o(tta), .end_of_table_echo_o(echo), .transfer_stop_o(stop),
    .input_direction_flag_o(idf), .busy_o(busy_o));
  its_mem_model mm (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rvalid_o(mem_rvalid_i),
    .rdata_o(mem_rdata_i));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Pulses are counted so late echo or stop still shows
  always @(posedge mclk_i)
  begin
    n_echo += (echo === 1'b1);
    n_stop += (stop === 1'b1);
    if (char_valid_o === 1'b1 && char_ready_i)
    begin
      check(exp_q.size() > 0 && {char_dev_o, char_op_o, char_data_o} === exp_q[0], "char");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end
  // One interrupt; expectation from the control word
  task automatic serve(input int ln, input bit stall);
    its_pkg::its_map_t m;
    logic [23:0] cw, nw, d;
    logic [24:0] s;
    logic cy, stp, ech;
    logic [4:0] r;
    int e0, s0, k;
    m = MAP[ln];
    cw = mm.mem[m.resp_addr];
    cy = cw[17:16] == 2'b11;
    s = {1'b0, cw} + 25'h001_0000 + (cw[17:16] == cw[15:14]);
    stp = s[24] | (cw[23:18] == 6'h3f && !cy);
    ech = !stp && cy && s[23:18] == 6'h3f;
    nw = s[23:0];
    if (nw[17:16] == 2'b00)
      nw[17:16] = cw[15:14];
    r = cw[15] ? (cw[14] ? 5'h00 : 5'h0c) : (cw[14] ? 5'h08 : 5'h06);
    d = mm.mem[nw[13:0]];
    d = (d << r) | (d >> (5'h18 - r));
    if (!stp)
      exp_q.push_back({m.dev_code, m.input_dir ? 3'h5 : 3'h4, d});
    e0 = n_echo;
    s0 = n_stop;
    irq_i[ln] = 1'b1;
    if (stall)
    begin
      repeat (80) @(posedge mclk_i);
      #2;
      check(busy_o === 1'b1 && tta === 1'b1, "no stall on full buffer");
      char_ready_i = 1'b1;
    end
    k = 0;
    while (irq_ack_o[ln] !== 1'b1 && k < 400)
    begin
      @(posedge mclk_i);
      #2;
      k++;
    end
    irq_i[ln] = 1'b0;
    check(idf === m.input_dir, "direction flag");
    check(k < 400, "no ack");
    if (k >= 400)
      give_verdict();
    repeat (4) @(posedge mclk_i);
    #2;
    check(mm.mem[m.resp_addr] === (stp ? cw : nw), "control word");
    check(stp || mm.mem[nw[13:0]] === d, "data word");
    check(n_echo - e0 == int'(ech) && n_stop - s0 == int'(stp), "echo or stop");
  endtask
  // Every packing mode, echo, then refused extra interrupts
  task automatic t_pack();
    for (int ln = 0; ln < 4; ln++)
    begin
      mm.mem[14'h0100 + ln] = {6'h3e, ln[1:0], ln[1:0], 14'h1000 + 14'(16 * ln - 1)};
      mm.mem[14'h1000 + 16 * ln] = 24'h12_3456 ^ 24'(ln);
      for (int i = 0; i < 6 - ln; i++)
        serve(ln, 1'b0);
    end
    $display("test pack done");
  endtask
  // Sink stalls: buffer fills, sequencer waits, then drains in order
  task automatic t_fifo();
    int k;
    mm.lat = 5;
    char_ready_i = 1'b0;
    mm.mem[14'h0100] = {6'h3a, 2'b00, 2'b00, 14'h0fff};
    for (int i = 0; i < 5; i++)
      mm.mem[14'h1000 + i] = 24'h0a_5c30 + 24'(i);
    for (int i = 0; i < 17; i++)
      serve(0, i == 16);
    k = 0;
    while (exp_q.size() > 0 && k < 100)
    begin
      @(posedge mclk_i);
      k++;
    end
    check(exp_q.size() == 0, "buffer not drained");
    $display("test fifo done");
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    #2;
    rstn_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #2;
    t_pack();
    t_fifo();
    give_verdict();
  end
endmodule
bind its_sequencer its_seq_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .irq_i(irq_i),
  .irq_ack_o(irq_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .char_op_o(char_op_o),
  .table_transfer_active_o(table_transfer_active_o),
  .end_of_table_echo_o(end_of_table_echo_o), .transfer_stop_o(transfer_stop_o),
  .busy_o(busy_o));
`default_nettype wire
